// file: logic/bfu_pkg.sv
// Shared constants and types of the variable bit field unit.
package bfu_pkg;

  // Operation select presented by the decode logic with each start pulse.
  typedef enum logic [2:0] {
    compare_signed_field,
    compare_unsigned_field,
    extract_signed_field,
    extract_unsigned_field,
    find_first_one,
    find_first_zero,
    insert_bit_field
  } bfu_op_t;

  typedef enum logic [1:0] {
    BFU_IDLE,
    BFU_FETCH,
    BFU_EXEC
  } bfu_state_t;

  // Field limits.
  localparam logic [7:0] BFU_MAX_SIZE    = 8'h20;
  localparam logic [31:0] BFU_MAX_REGPOS = 32'h0000_001f;
  localparam int          BFU_BYTE_BITS  = 8;
  localparam int          BFU_MEM_BYTES  = 5;

  // Condition code bit positions in the {N,Z,V,C} vector.
  localparam int BFU_CC_N = 3;
  localparam int BFU_CC_Z = 2;
  localparam int BFU_CC_V = 1;
  localparam int BFU_CC_C = 0;

  // Register port offsets and reset values.
  localparam logic [3:0] BFU_REG_CTRL   = 4'h0;
  localparam logic [3:0] BFU_REG_STATUS = 4'h4;
  localparam logic [3:0] BFU_REG_COUNT  = 4'h8;
  localparam logic       BFU_CTRL_RST   = 1'b1;
  localparam int         BFU_CTRL_EN    = 0;
  localparam int         BFU_STAT_FAULT = 4;

endpackage : bfu_pkg

// file: logic/bfu_unit.sv
// Variable bit field execution datapath with its operand handshake.
//
// Functional notes
// - Size above 32 raises a reserved operand fault; 0 to 32 are accepted.
// - Register base with nonzero size faults when position exceeds 31.
// - Register field sits in Rn, spilling into Rn+1 when pos+size > 32.
// - Memory field byte is base plus signed pos[31:3]; bit offset pos[2:0].
// - Memory access spans 1+((size-1)+pos[2:0])/8 bytes; none for size 0.
// - Compare uses sign or zero extended field; zero size counts as 0.
// - Compare sets N signed-less, Z equal, V clear, C unsigned-less only.
// - Extract writes extended field, 0 for size 0; N,Z result, V 0, C kept.
// - Faulting extract leaves destination unwritten.
// - Find scans upward from bit 0; hit writes position and clears Z.
// - No hit writes top+1, size 0 writes start; Z set; N,V,C cleared.
// - Faulting find leaves the result position unwritten.
// - Insert replaces field with low size source bits; size 0 changes nothing.
// - Faulting insert leaves the target field unmodified.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module bfu_unit
  import bfu_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Operand port from decode and operand fetch.
  input  wire logic        i_start,
  input  wire bfu_op_t     i_op,
  input  wire logic [31:0] i_pos,
  input  wire logic [7:0]  i_size,
  input  wire logic        i_reg_mode,
  input  wire logic [31:0] i_base,
  input  wire logic [31:0] i_src,
  input  wire logic [31:0] i_rn,
  input  wire logic [31:0] i_rn1,
  input  wire logic [3:0]  i_cc,
  // Memory operand handshake.
  input  wire logic        i_mem_valid,
  input  wire logic [39:0] i_mem_rdata,
  // Register port.
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // Results.
  output logic             o_busy,
  output logic             o_done,
  output logic             o_fault,
  output logic             o_cc_we,
  output logic      [3:0]  o_cc,
  output logic             o_dst_we,
  output logic      [31:0] o_dst,
  output logic             o_mem_rd,
  output logic             o_mem_we,
  output logic      [31:0] o_mem_addr,
  output logic      [2:0]  o_mem_bytes,
  output logic      [39:0] o_mem_wdata,
  output logic             o_rn_we,
  output logic      [31:0] o_rn_wdata,
  output logic             o_rn1_we,
  output logic      [31:0] o_rn1_wdata
);

  typedef struct packed {
    bfu_state_t  state;
    logic        busy;
    bfu_op_t     op;
    logic [31:0] pos;
    logic [7:0]  size;
    logic        reg_mode;
    logic [31:0] src;
    logic [31:0] rn;
    logic [31:0] rn1;
    logic [39:0] mem;
    logic [3:0]  cc_in;
    logic        ctrl_en;
    logic        last_fault;
    logic [3:0]  last_cc;
    logic [31:0] count;
    logic [31:0] rdata;
    logic        done;
    logic        fault;
    logic        cc_we;
    logic [3:0]  cc;
    logic        dst_we;
    logic [31:0] dst;
    logic        mem_rd;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [2:0]  mem_bytes;
    logic [39:0] mem_wdata;
    logic        rn_we;
    logic [31:0] rn_wdata;
    logic        rn1_we;
    logic [31:0] rn1_wdata;
  } bfu_regs_t;

  bfu_regs_t q;
  bfu_regs_t d;

  // Register-port address decode, used for both strobes.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    logic        bad;
    logic [63:0] win;
    logic [5:0]  sh;
    logic [31:0] raw;
    logic [31:0] mask;
    logic [31:0] field;
    logic [31:0] ext;
    logic        neg;
    logic [63:0] wmask;
    logic [63:0] nwin;
    logic        want;
    logic        found;
    logic [4:0]  idx;
    logic [8:0]  span;
    logic [7:0]  nbytes;
    d        = q;
    bad      = 1'b0;
    win      = 64'h0000_0000_0000_0000;
    sh       = 6'h00;
    raw      = 32'h0000_0000;
    mask     = 32'h0000_0000;
    field    = 32'h0000_0000;
    ext      = 32'h0000_0000;
    neg      = 1'b0;
    wmask    = 64'h0000_0000_0000_0000;
    nwin     = 64'h0000_0000_0000_0000;
    want     = 1'b0;
    found    = 1'b0;
    idx      = 5'h00;
    span     = 9'h000;
    nbytes   = 8'h00;
    d.done   = 1'b0;
    d.fault  = 1'b0;
    d.cc_we  = 1'b0;
    d.dst_we = 1'b0;
    d.mem_rd = 1'b0;
    d.mem_we = 1'b0;
    d.rn_we  = 1'b0;
    d.rn1_we = 1'b0;
    d.rdata  = 32'h0000_0000;

    // Register port: read data appear one cycle after the strobe only.
    // Clearing the enable only blocks new starts; an operation in flight ends.
    if (i_reg_wr && hit(i_reg_addr, BFU_REG_CTRL)) begin
      d.ctrl_en = i_reg_wdata[BFU_CTRL_EN];
    end
    if (i_reg_rd) begin
      if (hit(i_reg_addr, BFU_REG_CTRL)) begin
        d.rdata = {31'h0000_0000, q.ctrl_en};
      end else if (hit(i_reg_addr, BFU_REG_STATUS)) begin
        d.rdata[BFU_STAT_FAULT] = q.last_fault;
        d.rdata[3:0]            = q.last_cc;
      end else if (hit(i_reg_addr, BFU_REG_COUNT)) begin
        d.rdata = q.count;
      end
    end

    // Field geometry from the latched operands.
    if (q.reg_mode) begin
      win = {q.rn1, q.rn};
      sh  = {1'b0, q.pos[4:0]};
    end else begin
      // Memory window: up to five bytes, low byte at the field's address.
      win = {24'h00_0000, q.mem};
      sh  = {3'b000, q.pos[2:0]};
    end
    raw = 32'(win >> sh);
    if (q.size == BFU_MAX_SIZE) begin
      mask = 32'hffff_ffff;
    end else begin
      mask = (32'h0000_0001 << q.size[4:0]) - 32'h0000_0001;
    end
    field = raw & mask;
    if (q.size != 8'h00) begin
      neg = field[5'(q.size - 8'h01)];
    end
    ext = field;
    if (neg && (q.op == compare_signed_field ||
                q.op == extract_signed_field)) begin
      ext = field | ~mask;
    end
    wmask = {32'h0000_0000, mask} << sh;
    nwin  = (win & ~wmask) |
            ({32'h0000_0000, q.src & mask} << sh);

    // Find-zero looks for raw bits equal to 0, find-one for bits equal to 1.
    want  = (q.op == find_first_one);
    // Descending loop so the lowest matching bit is the one kept.
    for (int i = 31; i >= 0; i--) begin
      if (i < int'(q.size) && raw[i] == want) begin
        found = 1'b1;
        idx   = 5'(i);
      end
    end
    span   = {4'h0, q.pos[4:0]} + {1'b0, q.size};
    // Write-back length comes from the latched operands; the fetch length came from the raw ones.
    nbytes = ((q.size - 8'h01 + {5'h00, q.pos[2:0]}) >> 3) + 8'h01;

    case (q.state)
      BFU_IDLE: begin
        if (i_start && q.ctrl_en) begin
          d.op       = i_op;
          d.pos      = i_pos;
          d.size     = i_size;
          d.reg_mode = i_reg_mode;
          d.src      = i_src;
          d.rn       = i_rn;
          d.rn1      = i_rn1;
          d.cc_in    = i_cc;
          d.mem      = 40'h00_0000_0000;
          // Range checks use the raw operands, before anything is fetched.
          bad = (i_size > BFU_MAX_SIZE);
          if (i_reg_mode && i_size != 8'h00 &&
              i_pos > BFU_MAX_REGPOS) begin
            bad = 1'b1;
          end
          // Address and byte count are latched in register mode too, unused.
          d.mem_addr  = i_base + {{3{i_pos[31]}}, i_pos[31:3]};
          d.mem_bytes = 3'(((i_size - 8'h01 +
                             {5'h00, i_pos[2:0]}) >> 3) + 8'h01);
          if (bad) begin
            // Refused here, before any fetch or write can happen.
            d.done       = 1'b1;
            d.fault      = 1'b1;
            d.last_fault = 1'b1;
          end else if (i_reg_mode || i_size == 8'h00) begin
            d.state = BFU_EXEC;
          end else begin
            d.mem_rd = 1'b1;
            d.state  = BFU_FETCH;
          end
        end
      end
      BFU_FETCH: begin
        // No time limit: a partner that never answers leaves the unit busy.
        if (i_mem_valid) begin
          d.mem   = i_mem_rdata;
          d.state = BFU_EXEC;
        end
      end
      BFU_EXEC: begin
        d.state      = BFU_IDLE;
        d.done       = 1'b1;
        d.last_fault = 1'b0;
        d.count      = q.count + 32'h0000_0001;
        // Codes start from the caller's copy so untouched bits pass through.
        d.cc         = q.cc_in;
        case (q.op)
          compare_signed_field, compare_unsigned_field: begin
            d.cc_we           = 1'b1;
            d.cc[BFU_CC_N]    = $signed(ext) < $signed(q.src);
            d.cc[BFU_CC_Z]    = (ext == q.src);
            d.cc[BFU_CC_V]    = 1'b0;
            d.cc[BFU_CC_C]    = (ext < q.src);
          end
          extract_signed_field, extract_unsigned_field: begin
            d.dst_we          = 1'b1;
            d.dst             = ext;
            d.cc_we           = 1'b1;
            d.cc[BFU_CC_N]    = ext[31];
            d.cc[BFU_CC_Z]    = (ext == 32'h0000_0000);
            d.cc[BFU_CC_V]    = 1'b0;
          end
          find_first_one, find_first_zero: begin
            d.dst_we          = 1'b1;
            if (found) begin
              d.dst = q.pos + {27'h000_0000, idx};
            end else begin
              d.dst = q.pos + {24'h00_0000, q.size};
            end
            d.cc_we           = 1'b1;
            d.cc[BFU_CC_N]    = 1'b0;
            d.cc[BFU_CC_Z]    = ~found;
            d.cc[BFU_CC_V]    = 1'b0;
            d.cc[BFU_CC_C]    = 1'b0;
          end
          insert_bit_field: begin
            if (q.size != 8'h00) begin
              if (q.reg_mode) begin
                d.rn_we      = 1'b1;
                d.rn_wdata   = nwin[31:0];
                // Rn+1 is written only when the field spills past bit 31.
                d.rn1_we     = (span > {1'b0, BFU_MAX_SIZE});
                d.rn1_wdata  = nwin[63:32];
              end else begin
                d.mem_we     = 1'b1;
                d.mem_wdata  = nwin[39:0];
                d.mem_bytes  = 3'(nbytes);
              end
            end
          end
          default: begin
            // Unused op code: report a fault and write no result; count still advances, last_fault clears.
            d.fault = 1'b1;
          end
        endcase
        if (d.cc_we) begin
          d.last_cc = d.cc;
        end
      end
      default: begin
        d.state = BFU_IDLE;
      end
    endcase
    // Busy is registered so the port comes straight from a flip-flop.
    d.busy = (d.state != BFU_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q         <= '0;
      q.ctrl_en <= BFU_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_busy      = q.busy;
  assign o_done      = q.done;
  assign o_fault     = q.fault;
  assign o_cc_we     = q.cc_we;
  assign o_cc        = q.cc;
  assign o_dst_we    = q.dst_we;
  assign o_dst       = q.dst;
  assign o_mem_rd    = q.mem_rd;
  assign o_mem_we    = q.mem_we;
  assign o_mem_addr  = q.mem_addr;
  assign o_mem_bytes = q.mem_bytes;
  assign o_mem_wdata = q.mem_wdata;
  assign o_rn_we     = q.rn_we;
  assign o_rn_wdata  = q.rn_wdata;
  assign o_rn1_we    = q.rn1_we;
  assign o_rn1_wdata = q.rn1_wdata;

endmodule // bfu_unit

// file: verification/bfu_mem_model.sv
// Byte memory that answers the unit's field fetches and write-backs.
`timescale 1ns/1ps
module bfu_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_we,
  input  wire logic [31:0] i_mem_addr,
  input  wire logic [2:0]  i_mem_bytes,
  input  wire logic [39:0] i_mem_wdata,
  output logic             o_mem_valid,
  output logic      [39:0] o_mem_rdata
);
  logic [7:0] mem_q [64];
  int         wait_q;
  initial begin
    for (int i = 0; i < 64; i++) mem_q[i] = 8'(i) ^ 8'h5a;
    wait_q = -1;
    o_mem_valid = 1'b0;
    o_mem_rdata = '0;
  end
  // Stale read data is inverted each cycle so it can never pass as valid.
  always @(posedge i_clk) begin
    o_mem_valid <= 1'b0;
    if (i_mem_rd) wait_q <= i_slow ? 6 : 0;
    else if (wait_q > 0) wait_q <= wait_q - 1;
    if (!i_mem_rd && wait_q == 0) begin
      wait_q <= -1;
      o_mem_valid <= 1'b1;
      for (int b = 0; b < 5; b++)
        o_mem_rdata[8*b+:8] <= mem_q[6'(i_mem_addr + 32'(b))];
    end else
      o_mem_rdata <= ~o_mem_rdata;
    if (i_mem_we)
      for (int b = 0; b < 5; b++)
        if (b < int'(i_mem_bytes))
          mem_q[6'(i_mem_addr + 32'(b))] <= i_mem_wdata[8*b+:8];
  end
endmodule // bfu_mem_model

// file: verification/bfu_props.sv
// Port-level assertions for the bit field unit.
`timescale 1ns/1ps
module bfu_props
  import bfu_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_start,
  input wire bfu_op_t     i_op,
  input wire logic [31:0] i_pos,
  input wire logic [7:0]  i_size,
  input wire logic        i_reg_mode,
  input wire logic [31:0] i_base,
  input wire logic [3:0]  i_cc,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_fault,
  input wire logic        o_cc_we,
  input wire logic [3:0]  o_cc,
  input wire logic        o_dst_we,
  input wire logic [31:0] o_dst,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic [2:0]  o_mem_bytes,
  input wire logic        o_rn_we,
  input wire logic        o_rn1_we
);
  // Idle starts count as taken; the one start the bench gives with the enable clear has legal operands.
  logic        go, cmp, ext, fnd, c_q;
  bfu_op_t     op_q;
  logic [31:0] pos_q, base_q;
  logic [7:0]  size_q;
  assign go  = i_start && !o_busy;
  assign cmp = op_q inside {compare_signed_field, compare_unsigned_field};
  assign ext = op_q inside {extract_signed_field, extract_unsigned_field};
  assign fnd = op_q inside {find_first_one, find_first_zero};
  always_ff @(posedge i_clk) begin
    if (go) begin
      op_q   <= i_op;
      c_q    <= i_cc[BFU_CC_C];
      pos_q  <= i_pos;
      base_q <= i_base;
      size_q <= i_size;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  size_fault_a: assert property (
    go && i_size > BFU_MAX_SIZE |=> o_done && o_fault) else $error("big size");
  reg_pos_a: assert property (
    go && i_reg_mode && i_size != 8'h0 && i_size <= BFU_MAX_SIZE &&
    i_pos > BFU_MAX_REGPOS |=> o_fault) else $error("reg pos not refused");
  legal_ok_a: assert property (
    go && i_size <= BFU_MAX_SIZE && (!i_reg_mode || i_size == 8'h0 ||
    i_pos <= BFU_MAX_REGPOS) |=> !o_done && !o_fault) else $error("bad fault");
  fault_quiet_a: assert property (o_fault |-> o_done && !o_dst_we &&
    !o_cc_we && !o_mem_we && !o_mem_rd && !o_rn_we && !o_rn1_we)
    else $error("fault wrote");
  mem_addr_a: assert property (o_mem_rd |->
    o_mem_addr == base_q + {{3{pos_q[31]}}, pos_q[31:3]}) else $error("addr");
  mem_bytes_a: assert property (o_mem_rd |-> o_mem_bytes ==
    3'((32'(size_q) + 32'(pos_q[2:0]) - 32'h1) / 32'h8 + 32'h1))
    else $error("byte count");
  size_zero_a: assert property (go && i_size == 8'h0 |=> !o_mem_rd ##1
    (o_done && !o_mem_we && !o_rn_we && !o_rn1_we)) else $error("size 0");
  cmp_cc_a: assert property (o_done && !o_fault && cmp |-> o_cc_we &&
    !o_dst_we && !o_cc[BFU_CC_V] && !o_mem_we) else $error("compare");
  ext_cc_a: assert property (o_done && !o_fault && ext |-> o_dst_we &&
    !o_cc[BFU_CC_V] && o_cc[BFU_CC_C] == c_q && o_cc[BFU_CC_N] == o_dst[31]
    && o_cc[BFU_CC_Z] == (o_dst == 32'h0)) else $error("extract");
  find_cc_a: assert property (o_done && !o_fault && fnd |-> o_dst_we &&
    o_cc_we && !o_cc[BFU_CC_N] && !o_cc[BFU_CC_V] && !o_cc[BFU_CC_C])
    else $error("find");
  ins_cc_a: assert property (o_done && op_q == insert_bit_field |->
    !o_cc_we && !o_dst_we) else $error("insert");
  cover property (o_fault);
  cover property (o_mem_we);
  cover property (o_done && fnd && o_cc[BFU_CC_Z]);
endmodule // bfu_props
bind bfu_unit bfu_props chk_u (.*);

// file: verification/tb_top.sv
// Row-driven bench for the bit field unit and its memory partner.
`timescale 1ns/1ps
module tb_top
  import bfu_pkg::*;
;
  typedef struct {
    bfu_op_t op; logic [31:0] pos; logic [7:0] size; logic [31:0] src;
    logic flt; logic [63:0] val; logic [3:0] cc;
  } bfu_row_t;
  localparam logic [31:0] RN  = 32'h1234_5678;
  localparam logic [31:0] RN1 = 32'h8765_4321;
  logic        i_clk, i_nrst, i_start, i_reg_mode, i_mem_valid, i_reg_wr;
  logic        i_reg_rd, i_slow, o_busy, o_done, o_fault, o_cc_we, o_dst_we;
  logic        o_mem_rd, o_mem_we, o_rn_we, o_rn1_we;
  bfu_op_t     i_op;
  logic [31:0] i_pos, i_base, i_src, i_rn, i_rn1, i_reg_wdata, o_reg_rdata;
  logic [31:0] o_dst, o_mem_addr, o_rn_wdata, o_rn1_wdata;
  logic [7:0]  i_size;
  logic [3:0]  i_cc, i_reg_addr, o_cc;
  logic [2:0]  o_mem_bytes;
  logic [39:0] i_mem_rdata, o_mem_wdata, exp_w;
  int          n_mismatch, n_checks, n_ok;
  bfu_row_t rows[19] = '{
    '{extract_unsigned_field, 32'h4, 8'h8, '0, 0, 64'h67, 4'h1},
    '{extract_signed_field, 32'h0, 8'h4, '0, 0, 64'hffff_fff8, 4'h9},
    '{extract_signed_field, 32'h1c, 8'h8, '0, 0, 64'h11, 4'h1},
    '{extract_signed_field, 32'h1f, 8'h2, '0, 0, 64'hffff_fffe, 4'h9},
    '{extract_unsigned_field, 32'h0, 8'h20, '0, 0, 64'h1234_5678, 4'h1},
    '{extract_unsigned_field, 32'h28, 8'h0, '0, 0, 64'h0, 4'h5},
    '{extract_unsigned_field, 32'h0, 8'h21, '0, 1, '0, '0},
    '{extract_signed_field, 32'h20, 8'h1, '0, 1, '0, '0},
    '{insert_bit_field, 32'h20, 8'h4, 32'hf, 1, '0, '0},
    '{find_first_zero, 32'h0, 8'hff, '0, 1, '0, '0},
    '{compare_signed_field, 32'h0, 8'h4, 32'h0, 0, '0, 4'h8},
    '{compare_unsigned_field, 32'h0, 8'h4, 32'h9, 0, '0, 4'h9},
    '{compare_unsigned_field, 32'h0, 8'h0, 32'h0, 0, '0, 4'h4},
    '{find_first_one, 32'h4, 8'h8, '0, 0, 64'h4, 4'h0},
    '{find_first_zero, 32'h3, 8'h4, '0, 0, 64'h7, 4'h4},
    '{find_first_one, 32'h9, 8'h0, '0, 0, 64'h9, 4'h4},
    '{insert_bit_field, 32'h8, 8'h8, 32'hab, 0, 64'h8765_4321_1234_ab78, '0},
    '{insert_bit_field, 32'h1c, 8'h8, 32'hcd, 0, 64'h8765_432c_d234_5678, '0},
    '{insert_bit_field, 32'h4, 8'h0, 32'hff, 0, {RN1, RN}, '0}};
  bfu_unit dut_u (.*);
  bfu_mem_model mem_u (
    .i_clk       (i_clk),
    .i_slow      (i_slow),
    .i_mem_rd    (o_mem_rd),
    .i_mem_we    (o_mem_we),
    .i_mem_addr  (o_mem_addr),
    .i_mem_bytes (o_mem_bytes),
    .i_mem_wdata (o_mem_wdata),
    .o_mem_valid (i_mem_valid),
    .o_mem_rdata (i_mem_rdata)
  );
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  function automatic logic [39:0] win(input logic [31:0] a);
    for (int b = 0; b < 5; b++) win[8*b+:8] = 8'(a + 32'(b)) ^ 8'h5a;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input bfu_op_t op, input logic [31:0] pos,
      input logic [7:0] size, input logic md, input logic [31:0] base, src);
    @(posedge i_clk);
    i_start <= 1'b1;
    {i_op, i_pos, i_size, i_reg_mode, i_base, i_src} <= {op, pos, size, md, base, src};
    @(posedge i_clk);
    i_start <= 1'b0;
    for (int k = 0; k < 30; k++) begin
      @(negedge i_clk);
      if (o_done) break;
    end
    chk(64'(o_done), 64'h1);
    if (o_done && !o_fault) n_ok++;
  endtask
  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {wr, !wr, a, d};
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd} <= 2'h0;
    @(negedge i_clk);
    if (!wr) chk(64'(o_reg_rdata), 64'(d));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {i_nrst, i_start, i_reg_mode, i_reg_wr, i_reg_rd, i_slow} = '0;
    {i_pos, i_base, i_src, i_reg_wdata, i_size, i_reg_addr} = '0;
    {i_op, i_rn, i_rn1, i_cc} = {extract_unsigned_field, RN, RN1, 4'h1};
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    reg_op(1'b0, BFU_REG_CTRL, 32'h1);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].pos, rows[i].size, 1'b1, '0, rows[i].src);
      chk(64'(o_fault), 64'(rows[i].flt));
      if (!rows[i].flt && rows[i].op == insert_bit_field)
        chk({o_rn1_we ? o_rn1_wdata : RN1, o_rn_we ? o_rn_wdata : RN}, rows[i].val);
      else if (!rows[i].flt)
        chk(64'(o_cc), 64'(rows[i].cc));
      else
        chk(64'({o_dst_we, o_rn_we, o_rn1_we}), 64'h0);
      if (!rows[i].flt && rows[i].op inside {extract_signed_field,
          extract_unsigned_field, find_first_one, find_first_zero})
        chk(64'(o_dst), rows[i].val);
    end
    run(extract_unsigned_field, 32'hffff_fffd, 8'h8, 1'b0, 32'h20, '0);
    chk(64'(o_mem_addr), 64'h1f);
    chk(64'(o_mem_bytes), 64'h2);
    exp_w = win(32'h1f) >> 5;
    chk(64'(o_dst), 64'(exp_w[7:0]));
    i_slow <= 1'b1;
    run(insert_bit_field, 32'h7, 8'h20, 1'b0, 32'h10, 32'ha5c3_0f96);
    exp_w = (win(32'h10) & ~40'h7f_ffff_ff80) | (40'(32'ha5c3_0f96) << 7);
    chk(64'(o_mem_wdata), 64'(exp_w));
    chk(64'(o_mem_bytes), 64'h5);
    // Carry clear and overflow set on entry: extract keeps C and clears V.
    @(posedge i_clk);
    i_cc <= 4'h6;
    run(extract_unsigned_field, 32'h7, 8'h20, 1'b0, 32'h10, '0);
    chk(64'(o_dst), 64'ha5c3_0f96);
    chk(64'(o_cc), 64'h8);
    reg_op(1'b0, BFU_REG_STATUS, 32'h8);
    // With the enable clear a start must be ignored.
    reg_op(1'b1, BFU_REG_CTRL, 32'h0);
    reg_op(1'b0, BFU_REG_CTRL, 32'h0);
    @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk(64'({o_busy, o_done}), 64'h0);
    reg_op(1'b1, BFU_REG_CTRL, 32'h1);
    reg_op(1'b1, 4'hc, 32'hffff_ffff);
    reg_op(1'b0, 4'hc, 32'h0);
    reg_op(1'b0, BFU_REG_COUNT, 32'(n_ok));
    // A reset in mid fetch must drop the operation without completing it.
    @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    chk(64'({o_busy, o_done}), 64'h0);
    reg_op(1'b0, BFU_REG_COUNT, 32'h0);
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    stop_test;
  end
endmodule // tb_top
